// [tdcf_host_model.sv]
// tdcf_host_model: host side writer of tx buffers
// assumes: write port sampled on the rising edge of sys_clk
`timescale 1ns/10ps
`default_nettype none
module tdcf_host_model (
  input wire logic sys_clk,
  output logic host_wr,
  output logic [31:0] host_wr_data
);
  // idle bus at time zero
  initial begin
    host_wr = 1'h0;
    host_wr_data = 32'h0;
  end

  // one dword per cycle, strobe held across a burst
  task automatic put(input logic [31:0] d);
    @(posedge sys_clk);
    host_wr <= 1'h1;
    host_wr_data <= d;
  endtask : put

  // command A, command B, payload padded to the end alignment
  task automatic send_buf(input logic [31:0] a, input logic [31:0] b, input logic [7:0] base);
    int w;
    int m;
    put(a);
    put(b);
    w = (int'(a[20:16]) + int'(a[10:0]) + 3) / 4;
    m = (a[25:24] == 2'h1) ? 3 : (a[25:24] == 2'h2) ? 7 : 0;
    w = (w + m) & ~m;
    for (int i = 0; i < w; i++) begin
      put({base + 8'(4 * i + 3), base + 8'(4 * i + 2), base + 8'(4 * i + 1), base + 8'(4 * i)});
    end
    @(posedge sys_clk);
    host_wr <= 1'h0;
    host_wr_data <= ~host_wr_data; // released bus shows the last dword inverted
  endtask : send_buf
endmodule : tdcf_host_model
`default_nettype wire

// [tdcf_packer.sv]
// tdcf_packer: joins payload bytes of successive dwords into whole dwords
// assumes: no new input in the cycle after a last input with spill
`timescale 1ns/10ps
`default_nettype none
module tdcf_packer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  input wire logic [1:0] in_lo,
  input wire logic [2:0] in_cnt,
  input wire logic in_last,
  output logic out_valid,
  output logic [31:0] out_data,
  output logic [2:0] out_cnt,
  output logic out_last
);

  // low n bytes set
  function automatic logic [55:0] pk_mask(input logic [2:0] n);
    pk_mask = (56'h1 << {n, 3'h0}) - 56'h1;
  endfunction : pk_mask

  logic [55:0] acc;
  logic [2:0] acc_n;
  logic pend;
  logic [55:0] sh;
  logic [55:0] all_b;
  logic [3:0] n;

  // append the valid lanes behind the held bytes
  always_comb begin
    sh = 56'(in_data) >> {in_lo, 3'h0};
    all_b = acc | ((sh & pk_mask(in_cnt)) << {acc_n, 3'h0});
    n = 4'(acc_n) + 4'(in_cnt);
  end

  // accumulator and output word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc <= '0;
      acc_n <= '0;
      pend <= 1'b0;
      out_valid <= 1'b0;
      out_data <= '0;
      out_cnt <= '0;
      out_last <= 1'b0;
    end else if (pend) begin
      out_valid <= 1'b1; // spill of a packet end
      out_data <= acc[31:0];
      out_cnt <= acc_n;
      out_last <= 1'b1;
      acc <= '0;
      acc_n <= '0;
      pend <= 1'b0;
    end else if (in_valid && n >= 4'h4) begin
      out_valid <= 1'b1;
      out_data <= all_b[31:0];
      out_cnt <= 3'h4;
      out_last <= in_last && n == 4'h4;
      acc <= all_b >> 32;
      acc_n <= 3'(n - 4'h4);
      pend <= in_last && n != 4'h4;
    end else if (in_valid && in_last) begin
      out_valid <= 1'b1;
      out_data <= all_b[31:0];
      out_cnt <= n[2:0];
      out_last <= 1'b1;
      acc <= '0;
      acc_n <= '0;
    end else begin
      out_valid <= 1'b0;
      out_last <= 1'b0;
      if (in_valid) begin
        acc <= all_b;
        acc_n <= n[2:0];
      end
    end
  end

endmodule : tdcf_packer
`default_nettype wire

// [tdcf_pkg.sv]
// tdcf_pkg: constants, field layout and types of the tx command path
// assumes: included before every tdcf module, no imports anywhere
package tdcf_pkg;

  // ----------------------------------------
  // command A fields
  // ----------------------------------------
  localparam int A_IOC = 31;
  localparam int A_ALN_HI = 25;
  localparam int A_ALN_LO = 24;
  localparam int A_OFF_HI = 20;
  localparam int A_OFF_LO = 16;
  localparam int A_FIRST = 13;
  localparam int A_LAST = 12;
  localparam int A_SIZE_HI = 10;

  // ----------------------------------------
  // command B and status word fields
  // ----------------------------------------
  localparam int B_TAG_HI = 31;
  localparam int B_TAG_LO = 16;
  localparam int B_LEN_HI = 10;
  localparam int ST_ERR = 15;

  // ----------------------------------------
  // end alignment codes and masks (dwords)
  // ----------------------------------------
  localparam logic [1:0] ALN_4 = 2'h0;
  localparam logic [1:0] ALN_16 = 2'h1;
  localparam logic [1:0] ALN_32 = 2'h2;
  localparam logic [1:0] ALN_RSV = 2'h3;
  localparam logic [11:0] MSK_16 = 12'h003;
  localparam logic [11:0] MSK_32 = 12'h007;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam logic [11:0] FIFO_WORDS = 12'h400;
  localparam int STS_DEPTH = 16;
  localparam int STS_AW = 4;
  localparam logic [13:0] DW_BYTES = 14'h0004;

  typedef enum logic [2:0] {
    S_CMDA = 3'h1,
    S_CMDB = 3'h2,
    S_DATA = 3'h4
  } tdcf_state_t;

  // dwords spanned by offset plus payload
  function automatic logic [11:0] tdcf_words(input logic [4:0] off, input logic [10:0] size);
    logic [12:0] s;
    s = 13'(off) + 13'(size) + 13'h3;
    tdcf_words = 12'(s >> 2);
  endfunction : tdcf_words

  // round dword count up to the end alignment
  function automatic logic [11:0] tdcf_align(input logic [11:0] w, input logic [1:0] aln);
    logic [11:0] m;
    case (aln)
      ALN_16: m = MSK_16;
      ALN_32: m = MSK_32;
      default: m = 12'h000;
    endcase
    tdcf_align = (w + m) & ~m;
  endfunction : tdcf_align

  // first lane and byte count of a dword at byte base b within [s,e)
  function automatic logic [4:0] tdcf_span(input logic [13:0] b, input logic [13:0] s,
                                          input logic [13:0] e);
    logic [13:0] lo;
    logic [13:0] hi;
    lo = (s > b) ? s - b : 14'h0;
    hi = (e > b) ? e - b : 14'h0;
    if (hi > DW_BYTES) hi = DW_BYTES;
    if (lo >= hi) tdcf_span = 5'h00;
    else tdcf_span = {lo[1:0], 3'(hi - lo)};
  endfunction : tdcf_span

endpackage : tdcf_pkg

// [tdcf_sts_fifo.sv]
// tdcf_sts_fifo: status word fifo with level interrupt
// assumes: push while full is dropped, pop while empty ignored
`timescale 1ns/10ps
`default_nettype none
module tdcf_sts_fifo (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [31:0] push_data,
  input wire logic pop,
  input wire logic [4:0] level,
  input wire logic irq_en,
  output logic [31:0] head,
  output logic [4:0] count,
  output logic irq
);

  logic [31:0] mem [tdcf_pkg::STS_DEPTH];
  logic [tdcf_pkg::STS_AW-1:0] wp;
  logic [tdcf_pkg::STS_AW-1:0] rp;
  logic do_push;
  logic do_pop;

  assign do_push = push && count != 5'(tdcf_pkg::STS_DEPTH);
  assign do_pop = pop && count != 5'h00;
  assign head = mem[rp];
  // level interrupt on count threshold
  assign irq = irq_en && level != 5'h00 && count >= level;

  // storage
  always_ff @(posedge sys_clk) begin
    if (do_push) mem[wp] <= push_data;
  end

  // pointers and count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end else begin
      if (do_push) wp <= wp + 1'b1;
      if (do_pop) rp <= rp + 1'b1;
      count <= count + 5'(do_push) - 5'(do_pop);
    end
  end

endmodule : tdcf_sts_fifo
`default_nettype wire

// [tdcf_top.sv]
// tdcf_top: tx command parsing, payload trim, packet checks, status post
// assumes: host writes one dword per cycle of host_wr, command A, B, data
`timescale 1ns/10ps
`default_nettype none
module tdcf_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_wr,
  input wire logic [31:0] host_wr_data,
  input wire logic tx_error_clear,
  input wire logic tx_done_clear,
  input wire logic mac_word_taken,
  input wire logic sts_rd,
  input wire logic [4:0] sts_irq_level,
  input wire logic sts_irq_en,
  output logic tx_word_valid,
  output logic [31:0] tx_word,
  output logic [2:0] tx_word_cnt,
  output logic tx_word_last,
  output logic tx_error_flag,
  output logic tx_buffer_loaded_flag,
  output logic [11:0] tx_fifo_space_info,
  output logic [31:0] sts_data,
  output logic [4:0] sts_count,
  output logic sts_irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  tdcf_pkg::tdcf_state_t st;
  logic [31:0] cmd_a;
  logic [31:0] cmd_b;
  logic [11:0] tot;
  logic [11:0] widx;
  logic [11:0] byte_cnt;
  logic [11:0] used;
  logic in_pkt;
  logic pkt_err;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic wr_a;
  logic wr_b;
  logic wr_d;
  logic a_first;
  logic a_last;
  logic [4:0] a_off;
  logic [10:0] a_size;
  logic [1:0] a_aln;
  logic [11:0] tot_n;
  logic [4:0] sp;
  logic [2:0] cnt;
  logic buf_end;
  logic pkt_end;
  logic [31:0] eff_b;
  logic [11:0] bytes_now;
  logic tag_mis;
  logic b_mis;
  logic len_err;
  logic seq_err;
  logic aln_err;
  logic ovf;
  logic any_err;

  // host write phases
  assign wr_a = host_wr && st == tdcf_pkg::S_CMDA;
  assign wr_b = host_wr && st == tdcf_pkg::S_CMDB;
  assign wr_d = host_wr && st == tdcf_pkg::S_DATA;

  // command A fields, taken live during A and held after
  logic [31:0] a_src;
  assign a_src = wr_a ? host_wr_data : cmd_a;
  assign a_first = a_src[tdcf_pkg::A_FIRST];
  assign a_last = a_src[tdcf_pkg::A_LAST];
  assign a_off = a_src[tdcf_pkg::A_OFF_HI:tdcf_pkg::A_OFF_LO];
  assign a_size = a_src[tdcf_pkg::A_SIZE_HI:0];
  assign a_aln = a_src[tdcf_pkg::A_ALN_HI:tdcf_pkg::A_ALN_LO];

  // dwords the host sends, padded to the alignment
  assign tot_n = tdcf_pkg::tdcf_align(tdcf_pkg::tdcf_words(a_off, a_size), a_aln);

  // lanes of this dword that carry payload
  assign sp = tdcf_pkg::tdcf_span({widx, 2'h0}, 14'(a_off),
                                  14'(a_off) + 14'(a_size));
  assign cnt = wr_d ? sp[2:0] : 3'h0;

  // buffer and packet ends
  assign buf_end = (wr_b && tot_n == 12'h000) || (wr_d && widx == tot - 12'h001);
  assign pkt_end = buf_end && a_last;

  // command B of the packet as seen now
  assign eff_b = (wr_b && a_first) ? host_wr_data : cmd_b;
  assign bytes_now = byte_cnt + 12'(cnt);

  // packet checks
  assign tag_mis = wr_b && !a_first &&
                   host_wr_data[tdcf_pkg::B_TAG_HI:tdcf_pkg::B_TAG_LO] !=
                   cmd_b[tdcf_pkg::B_TAG_HI:tdcf_pkg::B_TAG_LO];
  assign b_mis = wr_b && !a_first && host_wr_data != cmd_b;
  assign len_err = pkt_end && bytes_now != 12'(eff_b[tdcf_pkg::B_LEN_HI:0]);
  assign seq_err = wr_a && (a_first == in_pkt);
  assign aln_err = wr_a && a_aln == tdcf_pkg::ALN_RSV;
  assign ovf = host_wr && tx_fifo_space_info == 12'h000;
  assign any_err = tag_mis || b_mis || len_err || seq_err || aln_err || ovf;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------

  // command A, command B, payload
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= tdcf_pkg::S_CMDA;
    end else begin
      case (st)
        tdcf_pkg::S_CMDA: if (wr_a) st <= tdcf_pkg::S_CMDB;
        tdcf_pkg::S_CMDB: if (wr_b) st <= buf_end ? tdcf_pkg::S_CMDA : tdcf_pkg::S_DATA;
        tdcf_pkg::S_DATA: if (buf_end) st <= tdcf_pkg::S_CMDA;
        default: st <= tdcf_pkg::S_CMDA;
      endcase
    end
  end

  // command capture
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_a <= '0;
      cmd_b <= '0;
      tot <= '0;
    end else begin
      if (wr_a) cmd_a <= host_wr_data;
      if (wr_b && a_first) cmd_b <= host_wr_data;
      if (wr_b) tot <= tot_n;
    end
  end

  // dword index inside the buffer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      widx <= '0;
    end else if (wr_b) begin
      widx <= '0;
    end else if (wr_d) begin
      widx <= widx + 12'h001;
    end
  end

  // packet byte total and open packet
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      byte_cnt <= '0;
      in_pkt <= 1'b0;
    end else begin
      if (wr_a && a_first) begin
        byte_cnt <= '0;
        in_pkt <= 1'b1;
      end else if (pkt_end) begin
        byte_cnt <= '0;
        in_pkt <= 1'b0;
      end else if (wr_d) begin
        byte_cnt <= bytes_now;
      end
    end
  end

  // error gathered over the open packet
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pkt_err <= 1'b0;
    end else if (pkt_end) begin
      pkt_err <= 1'b0;
    end else if (wr_a && a_first) begin
      pkt_err <= any_err;
    end else if (any_err) begin
      pkt_err <= 1'b1;
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------

  // sticky error, set beats clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_error_flag <= 1'b0;
    end else if (any_err) begin
      tx_error_flag <= 1'b1;
    end else if (tx_error_clear) begin
      tx_error_flag <= 1'b0;
    end
  end

  // buffer loaded flag, set beats clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_buffer_loaded_flag <= 1'b0;
    end else if (buf_end && a_src[tdcf_pkg::A_IOC]) begin
      tx_buffer_loaded_flag <= 1'b1;
    end else if (tx_done_clear) begin
      tx_buffer_loaded_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // payload and space
  // ----------------------------------------
  logic pk_valid;
  logic next_take;
  logic store;

  // an empty last buffer still closes the packet in the packer
  assign pk_valid = (wr_d && (cnt != 3'h0 || pkt_end)) || (wr_b && pkt_end);
  assign next_take = mac_word_taken && used != 12'h000;
  // a word past capacity is lost, the count stays at full
  assign store = tx_word_valid && (used != tdcf_pkg::FIFO_WORDS || next_take);
  assign tx_fifo_space_info = tdcf_pkg::FIFO_WORDS - used;

  tdcf_packer u_packer (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(pk_valid),
    .in_data(host_wr_data),
    .in_lo(sp[4:3]),
    .in_cnt(cnt),
    .in_last(pkt_end),
    .out_valid(tx_word_valid),
    .out_data(tx_word),
    .out_cnt(tx_word_cnt),
    .out_last(tx_word_last)
  );

  // stored dword occupancy
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      used <= '0;
    end else begin
      used <= used + 12'(store) - 12'(next_take);
    end
  end

  // ----------------------------------------
  // status
  // ----------------------------------------
  logic [31:0] sts_word;

  assign sts_word = {eff_b[tdcf_pkg::B_TAG_HI:tdcf_pkg::B_TAG_LO], pkt_err || any_err,
                     4'h0, eff_b[tdcf_pkg::B_LEN_HI:0]};

  tdcf_sts_fifo u_sts (
    .sys_clk(sys_clk),
    .rst(rst),
    .push(pkt_end),
    .push_data(sts_word),
    .pop(sts_rd),
    .level(sts_irq_level),
    .irq_en(sts_irq_en),
    .head(sts_data),
    .count(sts_count),
    .irq(sts_irq)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_ERR_HOLD: assert property (tx_error_flag && !tx_error_clear |=> tx_error_flag)
    else $error("error flag dropped without clear");
  AST_TAG_MIS: assert property (tag_mis |=> tx_error_flag)
    else $error("tag mismatch not flagged");
  AST_B_MIS: assert property (b_mis |=> tx_error_flag && (pkt_err || $past(pkt_end)))
    else $error("command B mismatch not flagged");
  AST_LEN: assert property (len_err |=> tx_error_flag)
    else $error("length mismatch not flagged");
  AST_OVF: assert property (host_wr && tx_fifo_space_info == 12'h000 |=> tx_error_flag)
    else $error("overfill not flagged");
  AST_DONE: assert property (buf_end && a_src[tdcf_pkg::A_IOC] |=> tx_buffer_loaded_flag)
    else $error("done flag missing");
  AST_SEQ: assert property (wr_a |=> st == tdcf_pkg::S_CMDB)
    else $error("command B not expected after A");
  AST_PUSH: assert property (pkt_end && !sts_rd && sts_count < 5'h10 |=>
                             sts_count == $past(sts_count) + 5'h01)
    else $error("status not posted");
  AST_TAG: assert property (pkt_end && sts_count == 5'h00 |=>
                            sts_data[tdcf_pkg::B_TAG_HI:tdcf_pkg::B_TAG_LO] ==
                            $past(eff_b[tdcf_pkg::B_TAG_HI:tdcf_pkg::B_TAG_LO]))
    else $error("tag not copied to status");
  AST_PAD: assert property (wr_d && cnt == 3'h0 && !pkt_end |=>
                            byte_cnt == $past(byte_cnt))
    else $error("padding counted as payload");
  AST_IRQ: assert property (sts_irq |-> sts_count >= sts_irq_level)
    else $error("status irq below level");

  COV_MULTI: cover property (wr_a && !a_first ##[1:40] pkt_end);
  COV_POST: cover property (pkt_end ##1 sts_count != 5'h00);
  COV_ERR: cover property (tag_mis ##1 tx_error_flag);
  COV_SPILL: cover property (tx_word_valid && tx_word_last && tx_word_cnt != 3'h4);

endmodule : tdcf_top
`default_nettype wire

// [tdcf_top_tb.sv]
// tdcf_top_tb: self-checking bench of the tx command path
// assumes: tdcf_pkg, tdcf_top and tdcf_host_model compiled first
`timescale 1ns/10ps
`default_nettype none
module tdcf_top_tb;
  logic sys_clk, rst, host_wr, tx_error_clear, tx_done_clear, mac_word_taken, sts_rd, sts_irq_en;
  logic [31:0] host_wr_data, tx_word, sts_data;
  logic [4:0] sts_irq_level, sts_count;
  logic tx_word_valid, tx_word_last, tx_error_flag, tx_buffer_loaded_flag, sts_irq;
  logic [2:0] tx_word_cnt;
  logic [11:0] tx_fifo_space_info;
  int err_total, n_tests, cyc, n_last;
  logic [7:0] got_q[$], exp_q[$];

  // ----------------------------------------
  // design, host model, clock, monitor
  // ----------------------------------------
  tdcf_top i_tdcf_top (.sys_clk, .rst, .host_wr, .host_wr_data, .tx_error_clear, .tx_done_clear,
    .mac_word_taken, .sts_rd, .sts_irq_level, .sts_irq_en, .tx_word_valid, .tx_word, .tx_word_cnt,
    .tx_word_last, .tx_error_flag, .tx_buffer_loaded_flag, .tx_fifo_space_info, .sts_data,
    .sts_count, .sts_irq);
  tdcf_host_model i_tdcf_host_model (.sys_clk, .host_wr, .host_wr_data);

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  // collect packed bytes and packet ends, cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (tx_word_valid === 1'h1) begin
      for (int b = 0; b < int'(tx_word_cnt); b++) got_q.push_back(tx_word[8 * b +: 8]);
      if (tx_word_last === 1'h1) n_last++;
    end
    if (cyc == 10000) begin
      err_total++;
      print_verdict;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] ca(input logic ioc, input logic [1:0] aln, input logic [4:0] off,
                                     input logic fst, input logic lst, input logic [10:0] sz);
    return {ioc, 5'h00, aln, 3'h0, off, 2'h0, fst, lst, 1'h0, sz};
  endfunction : ca

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic xbuf(input logic [31:0] a, input logic [15:0] tag, input logic [10:0] len,
                      input logic [7:0] base);
    for (int k = 0; k < int'(a[10:0]); k++) exp_q.push_back(base + 8'(int'(a[20:16]) + k));
    i_tdcf_host_model.send_buf(a, {tag, 5'h00, len}, base);
  endtask : xbuf

  task automatic cmp(input int lasts);
    settle;
    chk("bytes", got_q.size(), exp_q.size());
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) chk("byte", got_q[i], exp_q[i]);
    chk("lasts", n_last, lasts);
    got_q.delete();
    exp_q.delete();
    n_last = 0;
  endtask : cmp

  task automatic pop(input logic [31:0] exp, input logic [31:0] msk);
    chk("sts_data", sts_data & msk, exp);
    @(posedge sys_clk) sts_rd <= 1'h1;
    @(posedge sys_clk) sts_rd <= 1'h0;
    #1;
  endtask : pop

  task automatic clr_err;
    @(posedge sys_clk) tx_error_clear <= 1'h1;
    @(posedge sys_clk) tx_error_clear <= 1'h0;
    settle;
    chk("err_clr", tx_error_flag, 32'h0);
  endtask : clr_err

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("rst_err", tx_error_flag, 32'h0);
    chk("rst_done", tx_buffer_loaded_flag, 32'h0);
    chk("rst_space", tx_fifo_space_info, 32'h400);
    chk("rst_cnt", sts_count, 32'h0);
    chk("rst_valid", tx_word_valid, 32'h0);
  endtask : t_reset

  task automatic t_single;
    xbuf(ca(1'h1, tdcf_pkg::ALN_4, 5'h03, 1'h1, 1'h1, 11'h005), 16'hA5C3, 11'h005, 8'h10);
    cmp(1);
    chk("done", tx_buffer_loaded_flag, 32'h1);
    chk("err", tx_error_flag, 32'h0);
    chk("count", sts_count, 32'h1);
    pop({16'hA5C3, 5'h00, 11'h005}, 32'hFFFFFFFF);
    @(posedge sys_clk) tx_done_clear <= 1'h1;
    @(posedge sys_clk) tx_done_clear <= 1'h0;
    settle;
    chk("done_clr", tx_buffer_loaded_flag, 32'h0);
  endtask : t_single

  task automatic t_split;
    @(posedge sys_clk) sts_irq_level <= 5'h02;
    sts_irq_en <= 1'h1;
    xbuf(ca(1'h0, tdcf_pkg::ALN_16, 5'h1F, 1'h1, 1'h0, 11'h006), 16'h0777, 11'h012, 8'h40);
    xbuf(ca(1'h0, tdcf_pkg::ALN_32, 5'h01, 1'h0, 1'h0, 11'h009), 16'h0777, 11'h012, 8'h80);
    xbuf(ca(1'h0, tdcf_pkg::ALN_4, 5'h00, 1'h0, 1'h1, 11'h003), 16'h0777, 11'h012, 8'hC0);
    cmp(1);
    chk("err", tx_error_flag, 32'h0);
    chk("done", tx_buffer_loaded_flag, 32'h0);
    chk("irq_below", sts_irq, 32'h0);
    @(posedge sys_clk) sts_irq_level <= 5'h01;
    settle;
    chk("irq_at", sts_irq, 32'h1);
    pop({16'h0777, 5'h00, 11'h012}, 32'hFFFFFFFF);
    settle;
    chk("irq_empty", sts_irq, 32'h0);
  endtask : t_split

  task automatic t_errs;
    for (int c = 0; c < 4; c++) begin
      case (c)
        0: begin
          xbuf(ca(1'h0, 2'h0, 5'h00, 1'h1, 1'h0, 11'h004), 16'h0001, 11'h008, 8'h00);
          xbuf(ca(1'h0, 2'h0, 5'h00, 1'h0, 1'h1, 11'h004), 16'h0002, 11'h008, 8'h00);
        end
        1: xbuf(ca(1'h0, 2'h0, 5'h00, 1'h1, 1'h1, 11'h008), 16'h0003, 11'h00A, 8'h00);
        2: begin
          xbuf(ca(1'h0, 2'h0, 5'h00, 1'h1, 1'h0, 11'h006), 16'h0004, 11'h00C, 8'h00);
          xbuf(ca(1'h0, 2'h0, 5'h00, 1'h0, 1'h1, 11'h006), 16'h0004, 11'h00D, 8'h00);
        end
        default: xbuf(ca(1'h0, tdcf_pkg::ALN_RSV, 5'h00, 1'h1, 1'h1, 11'h004), 16'h0005, 11'h004, 8'h00);
      endcase
      settle;
      chk("err_set", tx_error_flag, 32'h1);
      settle;
      chk("err_hold", tx_error_flag, 32'h1);
      pop(32'h00008000, 32'h00008000);
      clr_err;
      got_q.delete();
      exp_q.delete();
      n_last = 0;
    end
  endtask : t_errs

  task automatic t_overfill;
    for (int p = 0; p < 3; p++) begin
      xbuf(ca(1'h0, 2'h0, 5'h00, 1'h1, 1'h1, 11'h7FC), 16'(p), 11'h7FC, 8'h00);
    end
    settle;
    chk("space_full", tx_fifo_space_info, 32'h0);
    chk("err_over", tx_error_flag, 32'h1);
    chk("count3", sts_count, 32'h3);
    @(posedge sys_clk) mac_word_taken <= 1'h1;
    repeat (1100) @(posedge sys_clk);
    mac_word_taken <= 1'h0;
    settle;
    chk("space_empty", tx_fifo_space_info, 32'h400);
    for (int p = 0; p < 3; p++) pop(32'(p) << 16, 32'hFFFF0000);
    clr_err;
    got_q.delete();
    exp_q.delete();
  endtask : t_overfill

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // reset for 6 cycles, then run every scenario
  initial begin
    rst = 1'h1;
    tx_error_clear = 1'h0;
    tx_done_clear = 1'h0;
    mac_word_taken = 1'h0;
    sts_rd = 1'h0;
    sts_irq_level = 5'h00;
    sts_irq_en = 1'h0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    #1;
    t_reset;
    t_single;
    t_split;
    t_errs;
    t_overfill;
    print_verdict;
  end
endmodule : tdcf_top_tb
`default_nettype wire
